/* src/ppo_pin_output.sv */
// Operation
// - Register at 0x384 holds output levels of pins 040-076 in bits 30:0, bit 31 reserved.
// - Register at 0x388 holds output levels of pins 100-136 in bits 30:0, bit 31 reserved.
// - Register at 0x38C holds output levels of pins 140-176 in bits 30:0, bit 31 reserved.
// - All pin output fields clear to zero while the main system reset is asserted.
// - A watchdog timeout seen while clk_en is high raises the main system clear and clears all fields.
`timescale 1ns/1ns
`default_nettype none
module ppo_pin_output
	import ppo_pkg::*;
#(
	parameter int NUM_REGS = ppo_pkg::PPO_NUM_REGS
) (
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	input  wire logic                                  clk_en,
	input  wire logic                                  watchdog_timeout,
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [ppo_pkg::PPO_ADDR_W-1:0]        paddr,
	input  wire logic [ppo_pkg::PPO_DATA_W-1:0]        pwdata,
	input  wire logic [3:0]                            pstrb,
	output logic      [ppo_pkg::PPO_DATA_W-1:0]        prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	input  wire logic [ppo_pkg::PPO_PINS_PER_REG*3-1:0] pin_is_output,
	output logic      [ppo_pkg::PPO_PINS_PER_REG*3-1:0] pin_out,
	output logic      [ppo_pkg::PPO_PINS_PER_REG*3-1:0] pin_oe
);
	import ppo_pkg::*;

	// elaboration check: map, arrays and pin vectors are sized for three groups
	if (NUM_REGS != PPO_NUM_REGS) begin : g_bad_num_regs
		$error("ppo_pin_output: only three output groups are supported");
	end

	// ***************************************************
	// main system clear
	// ***************************************************
	// watchdog raises clear
	// watchdog is on pclk, so no synchroniser; registered so clear is glitch-free
	// held while clk_en is low, so a frozen block never clears itself
	logic wdt_clear_ff;
	logic nxt_wdt_clear;
	always_comb begin
		nxt_wdt_clear = clk_en ? watchdog_timeout : wdt_clear_ff;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_clear_ff <= 1'b0;
		end else begin
			wdt_clear_ff <= nxt_wdt_clear;
		end
	end

	// ***************************************************
	// apb decode
	// ***************************************************
	logic       acc;
	logic [1:0] idx;
	logic       hit;
	assign acc     = psel & penable;
	assign pready  = 1'b1;            // zero wait states
	always_comb begin
		if (paddr == PPO_OFS_GRP_040_076) begin
			idx = 2'h0;
			hit = 1'b1;
		end else if (paddr == PPO_OFS_GRP_100_136) begin
			idx = 2'h1;
			hit = 1'b1;
		end else if (paddr == PPO_OFS_GRP_140_176) begin
			idx = 2'h2;
			hit = 1'b1;
		end else begin
			idx = 2'h0;
			hit = 1'b0;
		end
	end
	assign pslverr = acc & ~hit;      // unmapped address flagged

	// ***************************************************
	// output registers
	// ***************************************************
	logic [31:0] out_ff     [3];
	logic [31:0] nxt_out    [3];
	logic [31:0] strb_mask;
	always_comb begin
		strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	end
	// clear beats a write
	// clk_en low holds everything, a latched clear included
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			nxt_out[i] = out_ff[i];
			if (clk_en) begin
				if (wdt_clear_ff) begin
					nxt_out[i] = PPO_RESET_VAL;
				end else if (acc && pwrite && hit && idx == i[1:0]) begin
					nxt_out[i] = ((out_ff[i] & ~strb_mask) | (pwdata & strb_mask)) & PPO_WR_MASK;
				end
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++) begin
				out_ff[i] <= PPO_RESET_VAL;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				out_ff[i] <= nxt_out[i];
			end
		end
	end

	// ***************************************************
	// read data
	// ***************************************************
	// combinational read keeps zero-wait; data itself comes from flops
	// holes and idle read zero
	always_comb begin
		prdata = 32'h00000000;
		if (acc && !pwrite && hit) begin
			prdata = out_ff[idx];
		end
	end

	// ***************************************************
	// pins
	// ***************************************************
	// drive only outputs
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pins
			assign pin_out[g*31 +: 31] = out_ff[g][30:0] & pin_is_output[g*31 +: 31];
			assign pin_oe[g*31 +: 31]  = pin_is_output[g*31 +: 31];
		end
	endgenerate

	// ***************************************************
	// checks
	// ***************************************************
	property p_wr_grp0;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && acc && pwrite && paddr == PPO_OFS_GRP_040_076 && pstrb == 4'hF
			&& !wdt_clear_ff)
		|=> (out_ff[0] == ($past(pwdata) & PPO_WR_MASK));
	endproperty
	a_wr_grp0: assert property (p_wr_grp0) else $error("group 040 write lost");

	property p_wr_grp1;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && acc && pwrite && paddr == PPO_OFS_GRP_100_136 && pstrb == 4'hF
			&& !wdt_clear_ff)
		|=> (out_ff[1][30:0] == $past(pwdata[30:0]));
	endproperty
	a_wr_grp1: assert property (p_wr_grp1) else $error("group 100 write lost");

	property p_rd_grp2;
		@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && paddr == PPO_OFS_GRP_140_176) |-> (prdata == out_ff[2]);
	endproperty
	a_rd_grp2: assert property (p_rd_grp2) else $error("group 140 read wrong");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && wdt_clear_ff)
		|=> (out_ff[0] == 32'h0 && out_ff[1] == 32'h0 && out_ff[2] == 32'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("fields not cleared");

	sequence s_wdt;
		clk_en && watchdog_timeout ##1 clk_en;
	endsequence
	property p_wdt;
		@(posedge pclk) disable iff (!presetn)
		s_wdt |-> ##1 (out_ff[0] == 32'h0 && out_ff[1] == 32'h0
			&& out_ff[2] == 32'h0);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog did not clear");

	property p_rsvd;
		@(posedge pclk) disable iff (!presetn)
		!out_ff[0][31] && !out_ff[1][31] && !out_ff[2][31];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

	property p_pin_gate;
		@(posedge pclk) disable iff (!presetn)
		(pin_out & ~pin_is_output) == '0;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("input pin driven");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		!clk_en |=> ($stable(out_ff[0]) && $stable(out_ff[1]) && $stable(out_ff[2])
			&& $stable(wdt_clear_ff));
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while frozen");

	property p_wr_grp2;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && acc && pwrite && paddr == PPO_OFS_GRP_140_176 && pstrb == 4'hF
			&& !wdt_clear_ff)
		|=> (out_ff[2] == ($past(pwdata) & PPO_WR_MASK));
	endproperty
	a_wr_grp2: assert property (p_wr_grp2) else $error("group 140 write lost");

	property p_lane_keep;
		@(posedge pclk) disable iff (!presetn)
		(clk_en && acc && pwrite && paddr == PPO_OFS_GRP_040_076 && !pstrb[1]
			&& !wdt_clear_ff)
		|=> $stable(out_ff[0][15:8]);
	endproperty
	a_lane_keep: assert property (p_lane_keep) else $error("masked lane changed");

	property p_rd_rsvd;
		@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite) |-> !prdata[31];
	endproperty
	a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved bit read as one");
endmodule : ppo_pin_output
`default_nettype wire

/* src/ppo_pkg.sv */
package ppo_pkg;
	// ***************************************************
	// register map
	// ***************************************************
	localparam logic [11:0] PPO_OFS_GRP_040_076 = 12'h384;
	localparam logic [11:0] PPO_OFS_GRP_100_136 = 12'h388;
	localparam logic [11:0] PPO_OFS_GRP_140_176 = 12'h38C;
	localparam int          PPO_NUM_REGS        = 3;
	localparam int          PPO_DATA_W          = 32;
	localparam int          PPO_ADDR_W          = 12;
	// field layout: bits 30:0 writable, bit 31 reserved
	localparam logic [31:0] PPO_WR_MASK         = 32'h7FFFFFFF;
	localparam logic [31:0] PPO_RESET_VAL       = 32'h00000000;
	localparam int          PPO_PINS_PER_REG    = 31;
endpackage : ppo_pkg

/* verification/ppo_board.sv */
`timescale 1ns/1ns
`default_nettype none
// board side of the pins: a weak pull-down holds undriven pins low
module ppo_board (
	input  wire logic [92:0] pin_out,
	input  wire logic [92:0] pin_oe,
	output logic      [92:0] pin_level
);
	assign pin_level = pin_oe & pin_out;
endmodule : ppo_board
`default_nettype wire

/* verification/ppo_pin_output_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module ppo_pin_output_tb;
	import ppo_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wdt = 0, en = 1;
	logic [3:0]  strb = 4'hF;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, err;
	logic [92:0] pin_cfg = {3{31'h2AAAAAAA}}, pin_out, pin_oe, lvl;
	int          error_cnt = 0, num_checks = 0;
	logic [11:0] ofs [3] = '{PPO_OFS_GRP_040_076, PPO_OFS_GRP_100_136, PPO_OFS_GRP_140_176};
	logic [31:0] dv [3] = '{32'hFEDCBA98, 32'h80FF00FF, 32'hFFFFFFFF};
	// 100 MHz clock
	always #5 pclk = ~pclk;
	ppo_pin_output i_dut (.pclk(pclk), .presetn(presetn), .clk_en(en),
		.watchdog_timeout(wdt), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_is_output(pin_cfg), .pin_out(pin_out), .pin_oe(pin_oe));
	ppo_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(lvl));
	// one apb transfer; held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd       = prdata;
		err      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// read all three groups against one value
	task automatic rd_all(input logic [31:0] e);
		foreach (ofs[i]) begin
			xfer(1'b0, ofs[i], 32'h0);
			`CHK("group", e, rd)
		end
	endtask : rd_all
	task automatic wr_all;
		foreach (ofs[i]) xfer(1'b1, ofs[i], dv[i]);
	endtask : wr_all
	task automatic wrap_up;
		if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_all(32'h0);
		wr_all();
		foreach (ofs[i]) begin
			xfer(1'b0, ofs[i], 32'h0);
			`CHK("stored", dv[i] & PPO_WR_MASK, rd)
			`CHK("pins", dv[i][30:0] & 31'h2AAAAAAA, lvl[i*31 +: 31])
			`CHK("mapped err", 1'b0, err)
		end
		`CHK("pin enables", pin_cfg, pin_oe)
		xfer(1'b0, 12'h390, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		// a write to a hole is refused and leaves group 0 alone
		xfer(1'b1, 12'h390, 32'hFFFFFFFF);
		`CHK("unmapped wr err", 1'b1, err)
		xfer(1'b0, ofs[0], 32'h0);
		`CHK("after hole write", dv[0] & PPO_WR_MASK, rd)
		// timeout pulse must wipe everything, even a write landing with the clear
		fork
			xfer(1'b1, ofs[2], dv[2]);
			begin
				@(posedge pclk);
				wdt <= 1'b1;
				@(posedge pclk);
				wdt <= 1'b0;
			end
		join
		rd_all(32'h0);
		`CHK("pins after timeout", 93'h0, pin_out)
		// second reset in mid-run
		wr_all();
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd_all(32'h0);
		// only enabled byte lanes take the write
		strb <= 4'h5;
		xfer(1'b1, ofs[0], 32'hFFFFFFFF);
		strb <= 4'hF;
		xfer(1'b0, ofs[0], 32'h0);
		`CHK("lanes", 32'h00FF00FF, rd)
		// clock enable low freezes a write
		en <= 1'b0;
		xfer(1'b1, ofs[1], 32'h000000AA);
		xfer(1'b0, ofs[1], 32'h0);
		`CHK("frozen", 32'h0, rd)
		en <= 1'b1;
		wrap_up();
	end
	// hang guard, far beyond the under a hundred cycles needed
	initial begin
		#20000;
		error_cnt++;
		wrap_up();
	end
endmodule : ppo_pin_output_tb
`default_nettype wire
